// File: core/pph_header.sv
// pixel thread payload header builder with avalon-mm control registers
// assumes dispatcher presents one request per valid cycle from clk domain
`timescale 1ns/1ps
module pph_header #(
    parameter int SUBSPANS = 4 // subspans covered by the lit mask
) (
    input wire logic clk, // 20 MHz core clock
    input wire logic rstn, // async active low reset
    input wire logic [7:0] avs_address, // byte address
    input wire logic avs_read, // read strobe
    input wire logic avs_write, // write strobe
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic disp_valid, // dispatch request
    input wire logic [31:0] disp_cc_offset, // state record offset
    input wire logic [3:0] disp_scratch_code, // scratch size code
    input wire logic [31:0] disp_lit_mask, // lit pixels, 8 subspans
    output logic hdr_valid, // header valid, one-cycle pulse
    output logic [31:0] header_dword0, // lit mask and scratch code
    output logic [31:0] header_dword1, // state pointer
    output logic [31:0] header_dword2, // reserved zero
    output logic [31:0] dispatch_mask, // widened dispatch mask
    output logic [31:0] cc_ptr_out, // pointer to colour calc unit
    output logic [31:0] scratch_kb // decoded scratch size
);
    import pph_pkg::*;

    localparam int DW = $bits(header_dword0);
    localparam int NIBBLES = DW / SUBSPAN_PIX;
    localparam int GAP_W = MASK_LSB - SCR_W;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the lit mask field is four subspans of four pixels; no other count
    // has a place in the header
    if (SUBSPANS != 4) begin : g_bad_subspans
        $error("pph_header supports SUBSPANS of 4 only");
    end
    // a layout whose fields overlap, touch, or stop short of the top of a dword is refused
    if (PTR_LSB + PTR_W != DW) begin : g_bad_ptr
        $error("pointer field must end at the top of header dword 1");
    end
    if (MASK_LSB + MASK_W != DW) begin : g_bad_mask
        $error("lit mask field must end at the top of header dword 0");
    end
    if (SUBSPANS * SUBSPAN_PIX != MASK_W) begin : g_bad_pix
        $error("lit mask width must equal subspans times pixels");
    end
    if (SCR_W != $bits(disp_scratch_code) || GAP_W < 1) begin : g_bad_scr
        $error("scratch code must fit below the lit mask field");
    end
    if (CTRL_ERRATUM_BIT > 1 || CTRL_PIX32_BIT > 1) begin : g_bad_ctrl
        $error("control bits must lie in the two-bit control register");
    end

    // ************************************************************
    // field helpers
    // ************************************************************
    // control bits all live in byte lane 0, so only that lane can write
    function automatic logic wr_hit(input logic [7:0] a,
                                    input logic [7:0] target,
                                    input logic [3:0] be);
        wr_hit = (a == target) && be[0];
    endfunction : wr_hit

    // lit mask of the first four subspans only; upper subspans of a
    // 32 pixel dispatch are reached elsewhere, not through this field
    function automatic logic [MASK_W-1:0] lit_first4(
        input logic [DW-1:0] m
    );
        lit_first4 = m[MASK_W-1:0];
    endfunction : lit_first4

    // dword 0: lit mask on top, scratch code verbatim at the bottom and
    // the reserved gap between them zero
    function automatic logic [DW-1:0] pack_dw0(
        input logic [MASK_W-1:0] mask,
        input logic [SCR_W-1:0] code
    );
        pack_dw0 = {mask, {GAP_W{1'b0}}, code};
    endfunction : pack_dw0

    // the record is 64-byte aligned: bits below the pointer are reserved
    // and forced to zero whatever the dispatcher offers
    function automatic logic [DW-1:0] cc_ptr(input logic [DW-1:0] off);
        cc_ptr = {off[DW-1:PTR_LSB], {PTR_LSB{1'b0}}};
    endfunction : cc_ptr

    // a subspan goes fully active when any pixel of it is lit, so that
    // differences across the quad are taken from real neighbours
    function automatic logic [DW-1:0] widen(input logic [DW-1:0] m);
        logic [DW-1:0] r;
        r = RESET_WORD;
        for (int i = 0; i < NIBBLES; i++) begin
            r[i*SUBSPAN_PIX +: SUBSPAN_PIX] =
                {SUBSPAN_PIX{|m[i*SUBSPAN_PIX +: SUBSPAN_PIX]}};
        end
        widen = r;
    endfunction : widen

    function automatic logic [DW-1:0] ctrl_word(input logic [1:0] c);
        ctrl_word = DWORD_ZERO;
        ctrl_word[CTRL_ERRATUM_BIT] = c[CTRL_ERRATUM_BIT];
        ctrl_word[CTRL_PIX32_BIT] = c[CTRL_PIX32_BIT];
    endfunction : ctrl_word

    // only the big-allocation bit of step control is implemented
    function automatic logic [DW-1:0] step_word(input logic big);
        step_word = DWORD_ZERO;
        step_word[STEP_BIG_BIT] = big;
    endfunction : step_word

    // ************************************************************
    // state
    // ************************************************************
    logic [1:0] ctrl, next_ctrl;
    logic step_big, next_step_big;
    logic wreq, next_wreq;
    logic [DW-1:0] rdata, next_rdata;
    logic [DW-1:0] cnt, next_cnt;
    logic [DW-1:0] dec_kb, kb, next_kb;
    logic [DW-1:0] in_mask;
    logic v, next_v;
    logic [DW-1:0] d0, next_d0, d1, next_d1, d2, next_d2;
    logic [DW-1:0] dm, next_dm, cp, next_cp;

    // ************************************************************
    // control registers
    // ************************************************************
    // a write lands on the answer edge, the one edge at which the master
    // sees waitrequest low, so a stalled master never commits it early
    always_comb begin
        next_ctrl = ctrl;
        next_step_big = step_big;
        if (avs_write && !wreq) begin
            if (wr_hit(avs_address, ADDR_CTRL, avs_byteenable)) begin
                next_ctrl[CTRL_ERRATUM_BIT] =
                    avs_writedata[CTRL_ERRATUM_BIT];
                next_ctrl[CTRL_PIX32_BIT] = avs_writedata[CTRL_PIX32_BIT];
            end
            if (wr_hit(avs_address, ADDR_STEP_CTRL, avs_byteenable)) begin
                next_step_big = avs_writedata[STEP_BIG_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= RESET_CTRL;
            step_big <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            step_big <= next_step_big;
        end
    end

    // ************************************************************
    // bus handshake
    // ************************************************************
    // one wait cycle on every access: a request seen while waitrequest
    // is high is answered by waitrequest low on the next cycle; the
    // answer cycle never opens a new access, so a request held through
    // the answer edge is served once
    always_comb begin
        next_wreq = 1'b1;
        if ((avs_read || avs_write) && wreq) begin
            next_wreq = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wreq <= 1'b1;
        end else begin
            wreq <= next_wreq;
        end
    end

    // read data is loaded when the access is first seen and stands
    // through the answer cycle and until the next access
    always_comb begin
        next_rdata = rdata;
        if ((avs_read || avs_write) && wreq) begin
            unique case (avs_address)
                ADDR_CTRL: next_rdata = ctrl_word(ctrl);
                ADDR_STEP_CTRL: next_rdata = step_word(step_big);
                ADDR_STATUS: next_rdata = cnt;
                ADDR_SIZE_KB: next_rdata = kb;
                ADDR_ID: next_rdata = ID_VALUE;
                default: next_rdata = UNMAPPED_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= RESET_WORD;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // dispatch counter
    // ************************************************************
    // counts accepted dispatches for software and wraps at the top; the
    // increment reuses the one-unit constant of the size decoder
    always_comb begin
        next_cnt = cnt;
        if (disp_valid) begin
            next_cnt = cnt + KB_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= RESET_WORD;
        end else begin
            cnt <= next_cnt;
        end
    end

    // ************************************************************
    // scratch size
    // ************************************************************
    pph_scratch_dec u_dec (
        .code(disp_scratch_code),
        .erratum(ctrl[CTRL_ERRATUM_BIT]),
        .big_en(step_big),
        .size_kb(dec_kb)
    );

    // the decode follows the control bits as they stand at the dispatch
    // edge; a control write landing on that same edge counts from the next
    always_comb begin
        next_kb = kb;
        if (disp_valid) begin
            next_kb = dec_kb;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            kb <= RESET_WORD;
        end else begin
            kb <= next_kb;
        end
    end

    // ************************************************************
    // header assembly
    // ************************************************************
    // without 32 pixel dispatch the upper subspans carry no pixels
    always_comb begin
        in_mask = disp_lit_mask;
        if (!ctrl[CTRL_PIX32_BIT]) begin
            in_mask[DW-1:MASK_W] = '0;
        end
    end

    // one-cycle pulse per dispatch cycle; the header words stand after it
    always_comb begin
        next_v = disp_valid;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            v <= 1'b0;
        end else begin
            v <= next_v;
        end
    end

    always_comb begin
        next_d0 = d0;
        next_d1 = d1;
        next_d2 = DWORD_ZERO;
        if (disp_valid) begin
            next_d0 = pack_dw0(lit_first4(in_mask),
                               disp_scratch_code);
            next_d1 = cc_ptr(disp_cc_offset);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            d0 <= RESET_WORD;
            d1 <= RESET_WORD;
            d2 <= RESET_WORD;
        end else begin
            d0 <= next_d0;
            d1 <= next_d1;
            d2 <= next_d2;
        end
    end

    // the builder passes the pointer on to the colour calculation unit itself
    always_comb begin
        next_dm = dm;
        next_cp = cp;
        if (disp_valid) begin
            next_dm = widen(in_mask);
            next_cp = cc_ptr(disp_cc_offset);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dm <= RESET_WORD;
            cp <= RESET_WORD;
        end else begin
            dm <= next_dm;
            cp <= next_cp;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign avs_readdata = rdata;
    assign avs_waitrequest = wreq;
    assign hdr_valid = v;
    assign header_dword0 = d0;
    assign header_dword1 = d1;
    assign header_dword2 = d2;
    assign dispatch_mask = dm;
    assign cc_ptr_out = cp;
    assign scratch_kb = kb;
endmodule : pph_header

// File: core/pph_pkg.sv
// pixel thread payload header: shared constants, register map, field layout
// assumes a single 20 MHz core clock and an avalon-mm register master
package pph_pkg;
    // ************************************************************
    // register map (word aligned byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STEP_CTRL = 8'hD0;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SIZE_KB = 8'h08;
    localparam logic [7:0] ADDR_ID = 8'h0C;
    localparam logic [31:0] ID_VALUE = 32'h0000_5A01; // arbitrary value
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
    // ctrl bits
    localparam int CTRL_ERRATUM_BIT = 0;
    localparam int CTRL_PIX32_BIT = 1;
    localparam int STEP_BIG_BIT = 3;
    // ************************************************************
    // header field layout
    // ************************************************************
    localparam int PTR_LSB = 6;
    localparam int PTR_W = 26;
    localparam int MASK_LSB = 16;
    localparam int MASK_W = 16;
    localparam int SUBSPAN_PIX = 4;
    localparam int SCR_W = 4;
    localparam logic [3:0] SCR_MAX_CODE = 4'hB;
    localparam logic [3:0] SCR_BIG_CODE = 4'hB;
    localparam logic [31:0] KB_BIG = 32'h0000_0100;
    localparam logic [31:0] KB_BAD = 32'h0000_0000;
    localparam logic [31:0] DWORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] RESET_CTRL = 2'h0;
    localparam logic [31:0] KB_ONE = 32'h0000_0001;
    localparam logic [31:0] KB_BIG_ALIGN = 32'h0000_2000; // 8MB in KB
endpackage : pph_pkg

// File: core/pph_scratch_dec.sv
// scratch size decoder: turns the four-bit code into a size in KB
// assumes purely combinational use inside the header builder
`timescale 1ns/1ps
module pph_scratch_dec (
    input wire logic [3:0] code, // scratch size code
    input wire logic erratum, // early stepping selected
    input wire logic big_en, // code 11 means 256KB on erratum part
    output logic [31:0] size_kb // decoded size, zero if code illegal
);
    import pph_pkg::*;
    always_comb begin
        if (code > SCR_MAX_CODE) begin
            size_kb = KB_BAD;
        end else if (erratum && big_en && code == SCR_BIG_CODE) begin
            size_kb = KB_BIG;
        end else if (erratum) begin
            size_kb = {28'h0000000, code} + KB_ONE;
        end else begin
            size_kb = KB_ONE << code;
        end
    end
endmodule : pph_scratch_dec

// File: testbench/pph_sva.sv
// checker: bus answer timing and header field relations
// assumes one core clock and an async active-low reset
`timescale 1ns/1ps
module pph_sva (
    input wire logic clk, // clock
    input wire logic rstn, // reset
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic avs_waitrequest, // stall
    input wire logic disp_valid, // dispatch
    input wire logic [31:0] disp_cc_offset, // offset
    input wire logic [3:0] disp_scratch_code, // code
    input wire logic [31:0] disp_lit_mask, // lit
    input wire logic hdr_valid, // valid
    input wire logic [31:0] header_dword0, // dw0
    input wire logic [31:0] header_dword1, // dw1
    input wire logic [31:0] header_dword2, // dw2
    input wire logic [31:0] dispatch_mask, // mask
    input wire logic [31:0] cc_ptr_out // pointer
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_bus; s_req |=> s_ans; endproperty
    a_bus: assert property (p_bus) else $error("bus answer wrong");
    property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_hv; disp_valid |=> hdr_valid; endproperty
    a_hv: assert property (p_hv) else $error("no header");
    property p_d0; disp_valid |=> header_dword0 ==
        {$past(disp_lit_mask[15:0]), 12'h0, $past(disp_scratch_code)};
    endproperty
    a_d0: assert property (p_d0) else $error("dword0 wrong");
    property p_d1; disp_valid |=>
        header_dword1 == {$past(disp_cc_offset[31:6]), 6'h0}; endproperty
    a_d1: assert property (p_d1) else $error("dword1 wrong");
    property p_d2; hdr_valid |-> header_dword2 == 32'h0; endproperty
    a_d2: assert property (p_d2) else $error("dword2 not zero");
    property p_cc; hdr_valid |-> cc_ptr_out == header_dword1; endproperty
    a_cc: assert property (p_cc) else $error("pointer out wrong");
    property p_dm; disp_valid |=>
        ($past(disp_lit_mask[15:0]) & ~dispatch_mask[15:0]) == 16'h0;
    endproperty
    a_dm: assert property (p_dm) else $error("lit pixel dropped");
endmodule : pph_sva
bind pph_header pph_sva u_pph_sva (.*);

// File: testbench/pph_thread_model.sv
// thread stand-in: latches forwarded fields of each header
// assumes hdr_valid is a one-cycle pulse
`timescale 1ns/1ps
module pph_thread_model (
    input wire logic clk, // clock
    input wire logic hdr_valid, // valid
    input wire logic [31:0] header_dword0, // dw0
    output logic [3:0] fwd_code, // to data port
    output logic [15:0] fwd_lit // lit mask as received
);
    // kernel leaves code and lit mask untouched
    always_ff @(posedge clk) begin
        if (hdr_valid) begin
            fwd_code <= header_dword0[3:0];
            fwd_lit <= header_dword0[31:16];
        end
    end
endmodule : pph_thread_model

// File: testbench/tb.sv
// self-checking bench for the payload header builder
// assumes the bound checker and the thread model
`timescale 1ns/1ps
module tb;
    import pph_pkg::*;
    logic clk = 0, rstn = 0, rd = 0, wr = 0, dv = 0, wq, hv;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, off = 32'h0, lit = 32'h0, rdat, d0, d1, d2, dm;
    logic [31:0] ccp, kb;
    logic [3:0] code = 4'h0, fc;
    logic [3:0] be = 4'hF;
    logic [15:0] fl;
    int error_cnt = 0, compares = 0, cyc = 0;
    pph_header u_pph_header (.clk(clk), .rstn(rstn), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
        .disp_valid(dv), .disp_cc_offset(off), .disp_scratch_code(code),
        .disp_lit_mask(lit), .hdr_valid(hv), .header_dword0(d0),
        .header_dword1(d1), .header_dword2(d2), .dispatch_mask(dm),
        .cc_ptr_out(ccp), .scratch_kb(kb));
    pph_thread_model u_pph_thread_model (.clk(clk), .hdr_valid(hv),
        .header_dword0(d0), .fwd_code(fc), .fwd_lit(fl));
    initial forever #25 clk = ~clk;
    // ****
    // shared tasks
    // ****
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic disp(logic [31:0] o, logic [3:0] c, logic [31:0] m);
        @(posedge clk);
        dv <= 1'b1;
        off <= o;
        code <= c;
        lit <= m;
        @(posedge clk);
        dv <= 1'b0;
        @(negedge clk);
        chk({31'h0, hv}, 32'h1);
    endtask : disp
    function automatic logic [31:0] widen(logic [31:0] m);
        for (int i = 0; i < 8; i++) widen[4*i+:4] = {4{|m[4*i+:4]}};
    endfunction : widen
    // ****
    // scenarios
    // ****
    task automatic t_regs;
        logic [31:0] q;
        bus(1'b0, ADDR_ID, 32'h0, q);
        chk(q, ID_VALUE);
        bus(1'b0, 8'h40, 32'h0, q);
        chk(q, UNMAPPED_VALUE);
        $display("done regs");
    endtask : t_regs
    task automatic t_scr(logic e);
        logic [31:0] q;
        bus(1'b1, ADDR_CTRL, {31'h0, e}, q);
        for (int c = 0; c < 12; c++) begin
            disp(32'h0, 4'(c), 32'h0);
            chk(kb, e ? 32'(c + 1) : 32'(1 << c));
        end
        $display("done scratch decode");
    endtask : t_scr
    task automatic t_big;
        logic [31:0] q;
        // scratch base taken as 8MB aligned
        bus(1'b1, ADDR_STEP_CTRL, 32'h8, q);
        disp(32'h0, SCR_BIG_CODE, 32'h0);
        chk(kb, KB_BIG);
        bus(1'b1, ADDR_CTRL, 32'h0, q);
        disp(32'h0, SCR_BIG_CODE, 32'h0);
        chk(kb, 32'h0000_0800);
        $display("done big scratch");
    endtask : t_big
    task automatic t_hdr(logic p);
        logic [31:0] q, m;
        m = 32'h30C0_0901;
        bus(1'b1, ADDR_CTRL, {30'h0, p, 1'b0}, q);
        disp(32'hFFFF_FFFF, 4'h5, m);
        chk(d0, {m[15:0], 12'h0, 4'h5});
        chk(d1, 32'hFFFF_FFC0);
        chk(d2, DWORD_ZERO);
        chk(ccp, 32'hFFFF_FFC0);
        chk(dm, widen(p ? m : {16'h0, m[15:0]}));
        @(negedge clk);
        chk({12'h0, fc, fl}, {12'h0, 4'h5, m[15:0]});
        $display("done header");
    endtask : t_hdr
    // status readback after all dispatches, and a lane-0-less write
    task automatic t_stat;
        logic [31:0] q;
        bus(1'b0, ADDR_STATUS, 32'h0, q);
        chk(q, 32'h0000_001C); // 28 dispatches so far
        bus(1'b0, ADDR_SIZE_KB, 32'h0, q);
        chk(q, 32'h0000_0020);
        be <= 4'hE;
        bus(1'b1, ADDR_CTRL, 32'h0, q);
        be <= 4'hF;
        bus(1'b0, ADDR_CTRL, 32'h0, q);
        chk(q, 32'h0000_0002); // write without lane 0 ignored
        bus(1'b0, ADDR_STEP_CTRL, 32'h0, q);
        chk(q, 32'h0000_0008);
        $display("done status");
    endtask : t_stat
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_scr(1'b0);
        t_scr(1'b1);
        t_big;
        t_hdr(1'b0);
        t_hdr(1'b1);
        t_stat;
        finish_test;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            finish_test;
        end
    end
endmodule : tb
